// ### rtl/mafe_cfg_regs.sv
// Operation
// R1: Bits 6:4 select register (101 gain, 100 tx, 110 detect, 111 channel); load bits 3:0.
// R2: Bit 7 must match policy: one, zero or don't-care; mismatched bytes are dropped.
// R3: Gain 00=0dB, 01=+6dB default, 10=+12dB, 11=0dB with same band and loopback.
// R4: Bit 2 set disables receive filter; bit 3 disconnects it and disables offset.
// R5: Host keeps peak line level plus gain at most +3 dBm at filter input.
// R6: Tx code 0 sends modem/tone; codes 1-3 route auxiliary input via a filter.
// R7: Tx code 0100 in tone dialing sends only the high-group tone.
// R8: Tx code 1000 in tone dialing sends only the low-group tone.
// R9: Detect bits 2:0 set threshold -43..-29 dBm; bit 3 picks 3 or 3.5 dB.
// R10: Channel bit 1 picks wide band (0, default) or narrow band (1).
// R11: Channel bit 0 at 0 enables carrier detector delay, at 1 disables it.
// R12: Active tone detection forces wide receive band whatever the channel register.
// R13: Leaving tone detection restores the stored channel value, never overwritten.
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`include "mafe_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module mafe_cfg_regs (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Mode pins
  input  wire logic                  modem_or_tone_select,
  input  wire logic                  clock_source_select,
  input  wire logic                  rts_req,
  // Analog path controls
  output logic [1:0]                 rx_gain_code,
  output logic                       rx_loopback,
  output logic                       rx_filter_disable,
  output logic                       rx_filter_disconnect,
  output logic                       tx_modem_tone,
  output logic [1:0]                 tx_aux_filter,
  output logic                       tx_high_tone_only,
  output logic                       tx_low_tone_only,
  output logic [2:0]                 low_detect_threshold,
  output logic                       det_hyst_wide,
  output logic                       rx_narrow_band,
  output logic                       cld_delay_disable
);
  import mafe_pkg::*;

  mafe_nib_t rxgf_r;
  mafe_nib_t txp_r;
  mafe_nib_t det_r;
  mafe_nib_t rxch_r;
  mafe_pol_t pol_r;
  logic      rej_r;
  logic      wr_pend_r;
  logic [7:0] addr_r;
  logic [1:0] mod_s_r;
  logic [1:0] clk_s_r;
  logic [1:0] rts_s_r;

  function automatic logic b7_ok(input mafe_pol_t p, input logic b);
    b7_ok = (p == `MAFE_P_ONE)  ? b :
            (p == `MAFE_P_ZERO) ? !b : 1'b1;
  endfunction

  function automatic logic adr_hit(input logic [7:0] a, input logic [7:0] off);
    adr_hit = (a == off);
  endfunction

  wire        a_phase    = hsel && htrans[1] && hready;
  wire        wr_prog    = wr_pend_r && adr_hit(addr_r, `MAFE_OFF_PROG);
  wire        wr_pol     = wr_pend_r && adr_hit(addr_r, `MAFE_OFF_POLICY);
  wire        wr_stat    = wr_pend_r && adr_hit(addr_r, `MAFE_OFF_STATUS);
  wire [7:0]  pbyte      = hwdata[7:0];
  wire        b7_match   = b7_ok(pol_r, pbyte[`MAFE_B7_POS]);
  wire        prog_ok    = wr_prog && b7_match; // [R2]
  wire        prog_bad   = wr_prog && !b7_match;
  wire mafe_sel_t sel    = pbyte[`MAFE_SEL_MSB:`MAFE_SEL_LSB];
  wire mafe_nib_t pdat   = pbyte[`MAFE_DAT_MSB:`MAFE_DAT_LSB];
  wire        ld_rxgf    = prog_ok && (sel == `MAFE_SEL_RXGF);   // [R1]
  wire        ld_txp     = prog_ok && (sel == `MAFE_SEL_TXPATH); // [R1]
  wire        ld_det     = prog_ok && (sel == `MAFE_SEL_DET);    // [R1]
  wire        ld_rxch    = prog_ok && (sel == `MAFE_SEL_RXCH);   // [R1]
  // Tone detection is active with tone select low, clock source high, request high
  wire        tone_det   = !mod_s_r[1] && clk_s_r[1] && rts_s_r[1];
  wire        tone_dial  = !mod_s_r[1];
  wire        narrow_eff = rxch_r[1] && !tone_det; // [R10] [R12] [R13]
  wire        rej_nxt    = prog_bad || (rej_r && !(wr_stat && hwdata[`MAFE_ST_REJ_POS]));
  wire [31:0] status_w   = {13'h0000, rej_r, narrow_eff, tone_det,
                            rxch_r, det_r, txp_r, rxgf_r};
  wire [31:0] rd_nxt     = adr_hit(haddr, `MAFE_OFF_PROG)   ? 32'h00000000 :
                           adr_hit(haddr, `MAFE_OFF_POLICY) ? {30'h00000000, pol_r} :
                           adr_hit(haddr, `MAFE_OFF_STATUS) ? status_w : 32'h00000000;

  // Pin synchronisers, stage 0 read only by stage 1
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mod_s_r <= 2'h0;
      clk_s_r <= 2'h0;
      rts_s_r <= 2'h0;
    end else begin
      mod_s_r <= {mod_s_r[0], modem_or_tone_select};
      clk_s_r <= {clk_s_r[0], clock_source_select};
      rts_s_r <= {rts_s_r[0], rts_req};
    end
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_r <= a_phase && hwrite;
      addr_r    <= haddr;
      hrdata    <= (a_phase && !hwrite) ? rd_nxt : 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Configuration registers; the tone override never writes the channel store
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rxgf_r <= `MAFE_RST_RXGF;
      txp_r  <= `MAFE_RST_TXPATH;
      det_r  <= `MAFE_RST_DET;
      rxch_r <= `MAFE_RST_RXCH;
      pol_r  <= `MAFE_RST_POLICY;
      rej_r  <= 1'b0;
    end else begin
      if (ld_rxgf) begin
        rxgf_r <= pdat; // [R1]
      end
      if (ld_txp) begin
        txp_r <= pdat; // [R1]
      end
      if (ld_det) begin
        det_r <= pdat; // [R1]
      end
      if (ld_rxch) begin
        rxch_r <= pdat; // [R1] [R13]
      end
      if (wr_pol) begin
        pol_r <= hwdata[1:0];
      end
      rej_r <= rej_nxt; // [R2]
    end
  end

  // Decoded path controls
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_gain_code         <= 2'h1;
      rx_loopback          <= 1'b0;
      rx_filter_disable    <= 1'b0;
      rx_filter_disconnect <= 1'b0;
      tx_modem_tone        <= 1'b1;
      tx_aux_filter        <= 2'h0;
      tx_high_tone_only    <= 1'b0;
      tx_low_tone_only     <= 1'b0;
      low_detect_threshold <= 3'h0;
      det_hyst_wide        <= 1'b0;
      rx_narrow_band       <= 1'b0;
      cld_delay_disable    <= 1'b0;
    end else begin
      // Loopback code gives 0 dB gain
      rx_gain_code         <= (rxgf_r[1:0] == `MAFE_GAIN_LOOP) ? 2'h0 : rxgf_r[1:0]; // [R3]
      rx_loopback          <= (rxgf_r[1:0] == `MAFE_GAIN_LOOP); // [R3]
      rx_filter_disable    <= rxgf_r[2]; // [R4]
      rx_filter_disconnect <= rxgf_r[3]; // [R4]
      tx_modem_tone        <= (txp_r == `MAFE_RST_TXPATH); // [R6]
      tx_aux_filter        <= (txp_r[3:2] == 2'h0) ? txp_r[1:0] : 2'h0; // [R6]
      tx_high_tone_only    <= tone_dial && (txp_r == `MAFE_TX_HIGH); // [R7]
      tx_low_tone_only     <= tone_dial && (txp_r == `MAFE_TX_LOW); // [R8]
      low_detect_threshold <= det_r[2:0]; // [R9]
      det_hyst_wide        <= det_r[3]; // [R9]
      rx_narrow_band       <= narrow_eff; // [R10] [R12]
      cld_delay_disable    <= rxch_r[0]; // [R11]
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_load_gain;
    ld_rxgf ##1 (rxgf_r == $past(pdat));
  endsequence

  property p_sel_gain;
    ld_rxgf |-> s_load_gain;
  endproperty
  a_sel_gain: assert property (p_sel_gain) else $error("gain register not loaded"); // [R1]

  property p_sel_chan;
    ld_rxch |=> (rxch_r == $past(pdat)) ##1 (cld_delay_disable == $past(rxch_r[0]));
  endproperty
  a_sel_chan: assert property (p_sel_chan) else $error("channel register not loaded"); // [R1]

  property p_b7_drop;
    (wr_prog && (pol_r == `MAFE_P_ONE) && !pbyte[7]) |=>
      ($stable(rxgf_r) && $stable(txp_r) && $stable(det_r) && $stable(rxch_r) && rej_r);
  endproperty
  a_b7_drop: assert property (p_b7_drop) else $error("bad bit 7 byte accepted"); // [R2]

  property p_loop;
    (rxgf_r[1:0] == 2'h3) |=> (rx_loopback && (rx_gain_code == 2'h0));
  endproperty
  a_loop: assert property (p_loop) else $error("loopback code not decoded"); // [R3]

  property p_filt;
    ##1 (rx_filter_disable == $past(rxgf_r[2])) && (rx_filter_disconnect == $past(rxgf_r[3]));
  endproperty
  a_filt: assert property (p_filt) else $error("filter controls wrong"); // [R4]

  property p_aux;
    (txp_r inside {4'h1, 4'h2, 4'h3}) |=> (tx_aux_filter == $past(txp_r[1:0])) && !tx_modem_tone;
  endproperty
  a_aux: assert property (p_aux) else $error("auxiliary route wrong"); // [R6]

  property p_high;
    (tone_dial && (txp_r == 4'h4)) |=> (tx_high_tone_only && !tx_low_tone_only);
  endproperty
  a_high: assert property (p_high) else $error("high tone select wrong"); // [R7]

  property p_low;
    (!tone_dial || (txp_r != 4'h8)) |=> !tx_low_tone_only;
  endproperty
  a_low: assert property (p_low) else $error("low tone select outside tone dialing"); // [R8]

  property p_det;
    ld_det |=> ##1 (low_detect_threshold == $past(pdat[2:0], 2)) &&
                   (det_hyst_wide == $past(pdat[3], 2));
  endproperty
  a_det: assert property (p_det) else $error("detection level wrong"); // [R9]

  property p_force_wide;
    tone_det |=> !rx_narrow_band;
  endproperty
  a_force_wide: assert property (p_force_wide) else $error("wide band not forced"); // [R12]

  property p_restore;
    ($fell(tone_det) && !ld_rxch) |=> (rx_narrow_band == rxch_r[1]) && (rxch_r == $past(rxch_r));
  endproperty
  a_restore: assert property (p_restore) else $error("channel value not restored"); // [R10] [R13]

  sequence s_load_tx;
    ld_txp ##1 (txp_r == $past(pdat));
  endsequence

  property p_sel_tx;
    ld_txp |-> s_load_tx;
  endproperty
  a_sel_tx: assert property (p_sel_tx) else $error("tx path register not loaded"); // [R1]

  property p_sel_det;
    ld_det |=> (det_r == $past(pdat));
  endproperty
  a_sel_det: assert property (p_sel_det) else $error("detection register not loaded"); // [R1]

  property p_sel_other;
    (wr_prog && !sel[2]) |=>
      ($stable(rxgf_r) && $stable(txp_r) && $stable(det_r) && $stable(rxch_r));
  endproperty
  a_sel_other: assert property (p_sel_other) else $error("foreign code loaded"); // [R1]

  property p_b7_zero;
    (wr_prog && (pol_r == `MAFE_P_ZERO) && pbyte[`MAFE_B7_POS]) |=>
      ($stable(rxgf_r) && $stable(txp_r) && $stable(det_r) && $stable(rxch_r) && rej_r);
  endproperty
  a_b7_zero: assert property (p_b7_zero) else $error("byte with bit 7 set accepted"); // [R2]

  property p_rej_hold;
    (rej_r && !wr_stat) |=> rej_r;
  endproperty
  a_rej_hold: assert property (p_rej_hold) else $error("reject flag lost"); // [R2]

  property p_gain_pass;
    (rxgf_r[1:0] != `MAFE_GAIN_LOOP) |=> (rx_gain_code == $past(rxgf_r[1:0])) && !rx_loopback;
  endproperty
  a_gain_pass: assert property (p_gain_pass) else $error("gain not passed"); // [R3]

  property p_tx_modem;
    (txp_r == `MAFE_RST_TXPATH) |=> (tx_modem_tone && (tx_aux_filter == 2'h0));
  endproperty
  a_tx_modem: assert property (p_tx_modem) else $error("modem route not selected"); // [R6]

  property p_low_on;
    (tone_dial && (txp_r == `MAFE_TX_LOW)) |=> (tx_low_tone_only && !tx_high_tone_only);
  endproperty
  a_low_on: assert property (p_low_on) else $error("low tone not selected"); // [R8]

  property p_band;
    !tone_det |=> (rx_narrow_band == $past(rxch_r[1]));
  endproperty
  a_band: assert property (p_band) else $error("receive band not programmed"); // [R10]

  property p_cld;
    ##1 (cld_delay_disable == $past(rxch_r[0]));
  endproperty
  a_cld: assert property (p_cld) else $error("detector delay control wrong"); // [R11]

  property p_keep_store;
    (tone_det && !ld_rxch) |=> $stable(rxch_r);
  endproperty
  a_keep_store: assert property (p_keep_store) else $error("channel store changed"); // [R13]

endmodule

`default_nettype wire

// ### rtl/mafe_defines.svh
`ifndef MAFE_DEFINES_SVH
`define MAFE_DEFINES_SVH

// Bus offsets (byte addresses)
`define MAFE_OFF_PROG       8'h00
`define MAFE_OFF_POLICY     8'h04
`define MAFE_OFF_STATUS     8'h08

// Programming byte layout
`define MAFE_B7_POS         7
`define MAFE_SEL_MSB        6
`define MAFE_SEL_LSB        4
`define MAFE_DAT_MSB        3
`define MAFE_DAT_LSB        0

// Register select codes
`define MAFE_SEL_RXGF       3'h5
`define MAFE_SEL_TXPATH     3'h4
`define MAFE_SEL_DET        3'h6
`define MAFE_SEL_RXCH       3'h7

// Bit 7 policy codes
`define MAFE_P_ANY          2'h0
`define MAFE_P_ZERO         2'h1
`define MAFE_P_ONE          2'h2

// Reset values
`define MAFE_RST_RXGF       4'h1
`define MAFE_RST_TXPATH     4'h0
`define MAFE_RST_DET        4'h0
`define MAFE_RST_RXCH       4'h0
`define MAFE_RST_POLICY     2'h0

// Field codes
`define MAFE_GAIN_LOOP      2'h3
`define MAFE_TX_HIGH        4'h4
`define MAFE_TX_LOW         4'h8

// Status word field positions
`define MAFE_ST_RXGF_LSB    0
`define MAFE_ST_TX_LSB      4
`define MAFE_ST_DET_LSB     8
`define MAFE_ST_RXCH_LSB    12
`define MAFE_ST_TONE_POS    16
`define MAFE_ST_NARROW_POS  17
`define MAFE_ST_REJ_POS     18

`endif

// ### rtl/mafe_pkg.sv
package mafe_pkg;
  typedef logic [3:0] mafe_nib_t;
  typedef logic [2:0] mafe_sel_t;
  typedef logic [1:0] mafe_pol_t;
endpackage

// ### verif/mafe_host.sv
`timescale 1ns/1ns
`default_nettype none

module mafe_host (
  // Clock and bus answer
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Bus request
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // Hang flag
  output logic             hung
);
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hung = 1'b0;
  end

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1)
      hung <= 1'b1;
  endtask

  // Single word transfer; write data never leaks outside its data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hwdata <= ~d;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

`default_nettype wire

// ### verif/modem_afe_path_config_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none

module modem_afe_path_config_regs_bench;
  logic        sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, hung;
  logic [7:0]  haddr;
  logic [1:0]  htrans, gain, aux;
  logic [2:0]  hsize, thr;
  logic [31:0] hwdata, hrdata, q;
  logic        mode, cs, rts, loopb, fdis, fdisc, txm, hi, lo, hyst, nb, cld;
  int          gf, tx, det, ch, pol, rej, miscompares, total_checks;

  mafe_cfg_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .modem_or_tone_select(mode),
    .clock_source_select(cs), .rts_req(rts), .rx_gain_code(gain), .rx_loopback(loopb),
    .rx_filter_disable(fdis), .rx_filter_disconnect(fdisc), .tx_modem_tone(txm),
    .tx_aux_filter(aux), .tx_high_tone_only(hi), .tx_low_tone_only(lo),
    .low_detect_threshold(thr), .det_hyst_wide(hyst), .rx_narrow_band(nb),
    .cld_delay_disable(cld));

  mafe_host host (.clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hung(hung));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge sys_clk) if (hung) begin
    miscompares++;
    wrap_up();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_all();
    int tone, g, n, s;
    tone = (!mode && cs && rts) ? 1 : 0;
    g = gf & 3;
    n = ((ch >> 1) & 1) & !tone;
    chk(gain, (g == 3) ? 0 : g, "gain");
    chk(loopb, g == 3, "loopback");
    chk(fdis, (gf >> 2) & 1, "filter off");
    chk(fdisc, gf >> 3, "filter cut");
    chk(txm, tx == 0, "modem tone");
    chk(aux, (tx < 4) ? tx : 0, "aux filter");
    chk(hi, tx == 4 && !mode, "high tone");
    chk(lo, tx == 8 && !mode, "low tone");
    chk(thr, det & 7, "threshold");
    chk(hyst, det >> 3, "hysteresis");
    chk(nb, n, "narrow band");
    chk(cld, ch & 1, "detector delay");
    host.xfer(1'b0, 8'h08, 32'h0, q);
    chk(hresp, 0, "response");
    s = gf | tx << 4 | det << 8 | ch << 12 | tone << 16 | n << 17 | rej << 18;
    chk(q, s, "status");
  endtask

  // Model follows the byte, then outputs are compared two cycles after the load
  task automatic prog(input logic [7:0] b);
    int s;
    s = b[6:4];
    if ((pol == 1 && b[7]) || (pol == 2 && !b[7])) rej = 1;
    else if (s == 5) gf = b[3:0];
    else if (s == 4) tx = b[3:0];
    else if (s == 6) det = b[3:0];
    else if (s == 7) ch = b[3:0];
    host.xfer(1'b1, 8'h00, {24'h0, b}, q);
    repeat (2) @(posedge sys_clk);
    check_all();
  endtask

  task automatic pins(input logic m, input logic c, input logic r);
    mode <= m;
    cs <= c;
    rts <= r;
    repeat (5) @(posedge sys_clk);
    check_all();
  endtask

  initial begin
    {gf, tx, det, ch, pol, rej, miscompares, total_checks} = {32'd1, 224'd0};
    {sys_rst, mode, cs, rts} = 4'hC;
    void'($urandom(14018));
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    check_all();
    for (int s = 4; s < 8; s++)
      for (int d = 0; d < 16; d++)
        prog({1'b0, s[2:0], d[3:0]});
    pins(1'b0, 1'b0, 1'b0);
    prog(8'h44);
    prog(8'h48);
    prog(8'h72);
    pins(1'b0, 1'b1, 1'b1);
    prog(8'h73);
    pins(1'b1, 1'b1, 1'b1);
    for (int p = 0; p < 4; p++) begin
      pol = p;
      host.xfer(1'b1, 8'h04, p, q);
      host.xfer(1'b0, 8'h04, 32'h0, q);
      chk(q, p, "policy");
      repeat (12) prog(8'($urandom));
    end
    rej = 0;
    host.xfer(1'b1, 8'h08, 32'h0004_0000, q);
    host.xfer(1'b1, 8'h0C, $urandom, q);
    host.xfer(1'b0, 8'h0C, 32'h0, q);
    chk(q, 0, "unmapped");
    check_all();
    // Second reset in mid-run: every register back to its power-up value
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    {gf, tx, det, ch, pol, rej} = {32'd1, 160'd0};
    @(posedge sys_clk);
    check_all();
    wrap_up();
  end
endmodule

`default_nettype wire
